//--- rtl/tmc_core.sv
// How it works
// - Two select bits divide the bus clock by 1, 4, 8 or 16.
// - Sixteen-bit counter runs from zero after reset, stepping on prescaler ticks.
// - All-ones wraps to zero, sets overflow flag, counting continues.
// - Software has no way to load, clear or stop the counter.
// - Three capture, four compare, one channel selectable as either.
// - Each capture has a 16-bit latch, each compare a 16-bit value.
// - Every timer function except the watchdog has its own enable and own request line.
// - Accumulator, periodic and watchdog clocks are taps of the chain.
// - Accumulator is 8 bits, event counting or gated time mode.
// - Event mode counts each selected edge on the top pin.
// - Gated mode counts an internal clock while the pin holds level.
// - Periodic request at one of four selectable chain rates.
// - Watchdog ticks at bus clock divided by two to the fifteenth.
// - Missed service sequence resets the system and pulls reset pin low.
// - Each capture pin has an edge detector with selectable edge.
// - Port read returns live pin levels even in capture use.
// - Compare-owned pins ignore port data writes.
// - First compare may drive any mix of the five upper pins.
// - Top pin is port I/O, accumulator input or first compare output.
// - Edge codes reset to disabled; rise, fall, either for 01, 10, 11.
// - Captures latch a settled count, never one mid-increment.
`timescale 1ns/100ps
`include "tmc_defs.svh"
`default_nettype none
module tmc_core #(
  parameter int WDOG_TICKS = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output tmc_pkg::tmc_resp_t     s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output tmc_pkg::tmc_resp_t     s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire tmc_pkg::tmc_pin_t port_in,
  output tmc_pkg::tmc_pin_t      port_out,
  output tmc_pkg::tmc_pin_t      port_oe,
  output logic [`TMC_NFLAG-1:0]  irq_vec,
  output logic                   rst_pin_out_n
);
  import tmc_pkg::*;

  function automatic logic tap(input logic [15:0] c, input logic [4:0] n);
    logic [16:0] m;
    m = (17'h1 << n) - 17'h1;
    tap = ((c | ~m[15:0]) == 16'hffff);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (o & ~m) | (d & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave, one write and one read in flight
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r, rdata_r, rd_nxt, wval;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic        wr_go, wr_hit, rd_hit;

  assign wr_go = !awready_r && !wready_r && !bvalid_r;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `TMC_WDOG_OFS ||
             a[7:5] == `TMC_CHAN_BASE);
  endfunction

  assign wr_hit = mapped(waddr_r);
  assign rd_hit = mapped(s_axi_araddr);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        waddr_r   <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? 2'b00 : 2'b10;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= 2'b00;
    end else begin
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_hit ? rd_nxt : 32'h0;
        rresp_r   <= rd_hit ? 2'b00 : 2'b10;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [31:0]            ctrl_r;
  logic [7:0]             edge_r;
  logic [`TMC_NFLAG-1:0]  ien_r, flag_r, flag_set, flag_clr;
  logic [7:0]             port_data_r, port_dir_r;
  logic [4:0]             mmask_r, mdata_r;
  logic [1:0]             presc;
  logic                   pa_en, pa_gated, pa_pol, ch4_cap;
  logic [3:0]             ocen;

  assign wval     = merge(32'h0, wdata_r, wstrb_r);
  assign presc    = ctrl_r[`TMC_PSC_LSB +: 2];
  assign pa_en    = ctrl_r[`TMC_PA_EN];
  assign pa_gated = ctrl_r[`TMC_PA_GATED];
  assign pa_pol   = ctrl_r[`TMC_PA_POL];
  assign ch4_cap  = ctrl_r[`TMC_CH4_CAP];
  assign ocen     = ctrl_r[`TMC_OCEN_LSB +: 4];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r      <= `TMC_CTRL_RST;
      edge_r      <= `TMC_EDGE_RST;
      ien_r       <= '0;
      port_data_r <= 8'h00;
      port_dir_r  <= 8'h00;
      mmask_r     <= 5'h00;
      mdata_r     <= 5'h00;
    end else if (wr_go && wr_hit) begin
      unique case (waddr_r)
        `TMC_CTRL_OFS: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'hfff;
        `TMC_EDGE_OFS: edge_r <= wstrb_r[0] ? wdata_r[7:0] : edge_r;
        `TMC_IEN_OFS: begin
          ien_r[7:0]  <= wstrb_r[0] ? wdata_r[7:0] : ien_r[7:0];
          ien_r[11:8] <= wstrb_r[1] ? wdata_r[11:8] : ien_r[11:8];
        end
        `TMC_PORT_OFS: begin
          port_data_r <= wstrb_r[0] ? wdata_r[7:0] : port_data_r;
          port_dir_r  <= wstrb_r[1] ? wdata_r[15:8] : port_dir_r;
        end
        `TMC_MULTI_OFS: begin
          mmask_r <= wstrb_r[0] ? wdata_r[4:0] : mmask_r;
          mdata_r <= wstrb_r[1] ? wdata_r[12:8] : mdata_r;
        end
        default: ;
      endcase
    end
  end

  assign flag_clr = (wr_go && waddr_r == `TMC_FLAG_OFS) ?
                    wval[`TMC_NFLAG-1:0] : '0;

  // Set beats clear so no event is lost in the clearing cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r  <= '0;
      irq_vec <= '0;
    end else begin
      flag_r  <= (flag_r & ~flag_clr) | flag_set;
      irq_vec <= flag_r & ien_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain, prescaler and free-running counter
  logic [15:0] chain_r, cnt_r, cnt_nxt;
  logic        tick, pa_clk, rti_tick, wd_tick;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) chain_r <= 16'h0000;
    else chain_r <= chain_r + 16'h0001;
  end

  always_comb begin
    unique case (presc)
      2'b00: tick = 1'b1;
      2'b01: tick = tap(chain_r, 5'h02);
      2'b10: tick = tap(chain_r, 5'h03);
      2'b11: tick = tap(chain_r, 5'h04);
    endcase
  end

  assign pa_clk   = tap(chain_r, `TMC_TAP_PA);
  assign rti_tick = tap(chain_r,
                        5'(`TMC_TAP_RTI + 5'(ctrl_r[3:2])));
  assign wd_tick  = tap(chain_r, `TMC_TAP_WD);
  assign cnt_nxt  = cnt_r + 16'h0001;

  // No bus path reaches the counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 16'h0000;
    else if (tick) cnt_r <= cnt_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, a level changes when stages two and three agree
  logic [7:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt, rise, fall;

  assign lvl_nxt = ((s2_r ~^ s3_r) & s2_r) | ((s2_r ^ s3_r) & lvl_r);
  assign rise    = lvl_nxt & ~lvl_r;
  assign fall    = ~lvl_nxt & lvl_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r  <= 8'h00;
      s2_r  <= 8'h00;
      s3_r  <= 8'h00;
      lvl_r <= 8'h00;
    end else begin
      s1_r  <= port_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture and compare channels: 0..2 capture, 3 either, 4 multi-pin,
  // 5..7 single-pin compares
  logic [15:0] chan_r [8];
  logic [3:0]  cap_ev;
  logic [7:0]  match;
  logic [2:0]  widx;
  logic        wchan;
  logic [7:3]  cmp_ok_r;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cap
      tmc_edge_t sel;
      assign sel = tmc_edge_t'(edge_r[2*gi +: 2]);
      assign cap_ev[gi] = (gi < 3 || ch4_cap) &&
        ((sel == TMC_EDGE_RISE && rise[gi]) ||
         (sel == TMC_EDGE_FALL && fall[gi]) ||
         (sel == TMC_EDGE_ANY && (rise[gi] || fall[gi])));
      assign match[gi] = (gi == 3) && !ch4_cap && tick && cmp_ok_r[3] &&
                         cnt_nxt == chan_r[gi];
    end
    for (gi = 4; gi < 8; gi++) begin : g_cmp
      assign match[gi] = tick && cmp_ok_r[gi] &&
                         cnt_nxt == chan_r[gi];
    end
  endgenerate

  assign widx  = waddr_r[4:2];
  assign wchan = wr_go && waddr_r[7:5] == `TMC_CHAN_BASE &&
                 waddr_r[1:0] == 2'b00 &&
                 (widx[2] || (widx == 3'h3 && !ch4_cap));

  // Value registers power up unknown, so a compare stays quiet until loaded
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cmp_ok_r <= 5'h00;
    else if (wchan) cmp_ok_r[widx] <= 1'b1;
  end

  // Latches read the count as it stood before this edge's step, so a
  // capture never sees a half-updated value
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (i < 4 && cap_ev[i]) chan_r[i] <= cnt_r;
      else if (wchan && widx == 3'(i)) begin
        if (wstrb_r[0]) chan_r[i][7:0] <= wdata_r[7:0];
        if (wstrb_r[1]) chan_r[i][15:8] <= wdata_r[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse accumulator on the top pin
  logic [7:0] pacnt_r;
  logic       pa_edge, pa_inc;

  assign pa_edge = pa_en && (pa_pol ? rise[7] : fall[7]);
  assign pa_inc  = pa_en && (pa_gated ? (pa_clk && lvl_r[7] == pa_pol)
                                      : pa_edge);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pacnt_r <= 8'h00;
    else if (wr_go && waddr_r == `TMC_PACNT_OFS && wstrb_r[0])
      pacnt_r <= wdata_r[7:0];
    else if (pa_inc) pacnt_r <= pacnt_r + 8'h01;
  end

  always_comb begin
    flag_set = '0;
    flag_set[3:0] = cap_ev;
    flag_set[7:3] = flag_set[7:3] | match[7:3];
    flag_set[`TMC_FLG_TOV]  = tick && cnt_r == 16'hffff;
    flag_set[`TMC_FLG_RTI]  = rti_tick;
    flag_set[`TMC_FLG_PAOV] = pa_inc && pacnt_r == 8'hff;
    flag_set[`TMC_FLG_PAED] = pa_edge;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare-driven pin levels and port drive
  logic [7:0] comp_lvl_r, own, out_nxt, oe_nxt;

  always_comb begin
    own = 8'h00;
    for (int k = 0; k < 4; k++)
      own[6-k] = ocen[k] && (k < 3 || !ch4_cap);
    own[7:3] = own[7:3] | mmask_r;
    if (pa_en) own[7] = 1'b0;
    out_nxt = (own & comp_lvl_r) | (~own & port_data_r);
    oe_nxt  = (own | port_dir_r) & 8'hf8;
    if (pa_en) oe_nxt[7] = 1'b0;
    if (ch4_cap || !own[3]) oe_nxt[3] = port_dir_r[3];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) comp_lvl_r <= 8'h00;
    else begin
      for (int k = 0; k < 4; k++)
        if (match[k == 3 ? 3 : 5 + k]) comp_lvl_r[6-k] <= ~comp_lvl_r[6-k];
      // First compare wins over a single-pin toggle in the same tick
      if (match[4])
        for (int j = 0; j < 5; j++)
          if (mmask_r[j]) comp_lvl_r[3+j] <= mdata_r[j];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_out <= 8'h00;
      port_oe  <= 8'h00;
    end else begin
      port_out <= out_nxt;
      port_oe  <= oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  tmc_wd_t     wd_st_r;
  logic [15:0] wd_cnt_r;
  logic [3:0]  rst_hold_r;
  logic        wd_wr, wd_to;

  assign wd_wr = wr_go && waddr_r == `TMC_WDOG_OFS && wstrb_r[0];
  assign wd_to = wd_tick && wd_cnt_r == 16'(WDOG_TICKS - 1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_st_r    <= TMC_WD_IDLE;
      wd_cnt_r   <= 16'h0000;
      rst_hold_r <= 4'h0;
    end else begin
      if (wd_wr) begin
        unique case (wd_st_r)
          TMC_WD_IDLE:  wd_st_r <= (wdata_r[7:0] == `TMC_WD_KEY1) ?
                                   TMC_WD_ARMED : TMC_WD_IDLE;
          TMC_WD_ARMED: wd_st_r <= TMC_WD_IDLE;
        endcase
      end
      if (wd_wr && wd_st_r == TMC_WD_ARMED &&
          wdata_r[7:0] == `TMC_WD_KEY2) wd_cnt_r <= 16'h0000;
      else if (wd_to) wd_cnt_r <= 16'h0000;
      else if (wd_tick) wd_cnt_r <= wd_cnt_r + 16'h0001;
      if (wd_to) rst_hold_r <= 4'(`TMC_RST_CYC);
      else if (rst_hold_r != 4'h0) rst_hold_r <= rst_hold_r - 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rst_pin_out_n <= 1'b1;
    else rst_pin_out_n <= !(wd_to || rst_hold_r > 4'h1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  always_comb begin
    rd_nxt = 32'h0;
    if (s_axi_araddr[7:5] == `TMC_CHAN_BASE)
      rd_nxt = {16'h0, chan_r[s_axi_araddr[4:2]]};
    else begin
      unique case (s_axi_araddr)
        `TMC_CTRL_OFS:  rd_nxt = ctrl_r;
        `TMC_EDGE_OFS:  rd_nxt = {24'h0, edge_r};
        `TMC_IEN_OFS:   rd_nxt = {20'h0, ien_r};
        `TMC_FLAG_OFS:  rd_nxt = {20'h0, flag_r};
        `TMC_COUNT_OFS: rd_nxt = {16'h0, cnt_r};
        `TMC_PACNT_OFS: rd_nxt = {24'h0, pacnt_r};
        `TMC_PORT_OFS:  rd_nxt = {16'h0, port_dir_r, lvl_r};
        `TMC_MULTI_OFS: rd_nxt = {19'h0, mdata_r, 3'h0, mmask_r};
        `TMC_WDOG_OFS:  rd_nxt = {31'h0, wd_st_r};
        default:        rd_nxt = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wrap;
    tick && cnt_r == 16'hffff;
  endsequence

  psc_div16_a: assert property ((presc == 2'b11 && tick) |->
    chain_r[3:0] == 4'hf) else $error("prescale 16 tick off");
  cnt_step_a: assert property (tick |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not step by one");
  cnt_hold_a: assert property (!tick |=> cnt_r == $past(cnt_r))
    else $error("counter moved without tick");
  cnt_wrap_a: assert property (s_wrap |=> cnt_r == 16'h0000 &&
    flag_r[`TMC_FLG_TOV]) else $error("wrap lost");
  cap_latch_a: assert property (cap_ev[0] |=> chan_r[0] == $past(cnt_r))
    else $error("capture value wrong");
  cap_off_a: assert property (edge_r[1:0] == 2'b00 |-> !cap_ev[0])
    else $error("disabled capture fired");
  pa_evt_a: assert property ((pa_inc && !wr_go) |=>
    pacnt_r == $past(pacnt_r) + 8'h01)
    else $error("accumulator missed step");
  wd_reset_a: assert property (wd_to |=> !rst_pin_out_n [*3])
    else $error("watchdog reset pulse short");
  pin_own_a: assert property (own[6] |=> port_out[6] == $past(comp_lvl_r[6]))
    else $error("owned pin followed port data");
  rti_flag_a: assert property (rti_tick |=> flag_r[`TMC_FLG_RTI])
    else $error("periodic flag not set");
endmodule
`default_nettype wire

//--- rtl/tmc_defs.svh
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
// Register byte offsets
`define TMC_CTRL_OFS   8'h00
`define TMC_EDGE_OFS   8'h04
`define TMC_IEN_OFS    8'h08
`define TMC_FLAG_OFS   8'h0c
`define TMC_COUNT_OFS  8'h10
`define TMC_PACNT_OFS  8'h14
`define TMC_PORT_OFS   8'h18
`define TMC_MULTI_OFS  8'h1c
`define TMC_WDOG_OFS   8'h20
`define TMC_CHAN_BASE  3'h2
// Control field positions
`define TMC_PSC_LSB    0
`define TMC_RTI_LSB    2
`define TMC_PA_EN      4
`define TMC_PA_GATED   5
`define TMC_PA_POL     6
`define TMC_CH4_CAP    7
`define TMC_OCEN_LSB   8
`define TMC_MDATA_LSB  8
// Flag positions; 0..7 follow the channel index
`define TMC_FLG_TOV    8
`define TMC_FLG_RTI    9
`define TMC_FLG_PAOV   10
`define TMC_FLG_PAED   11
`define TMC_NFLAG      12
// Reset values
`define TMC_CTRL_RST   32'h0000_0000
`define TMC_EDGE_RST   8'h00
// Divider chain taps
`define TMC_TAP_PA     5'h06
`define TMC_TAP_RTI    5'h0d
`define TMC_TAP_WD     5'h0f
// Watchdog service keys
`define TMC_WD_KEY1    8'h55
`define TMC_WD_KEY2    8'haa
// Timing
`define TMC_CLK_NS     40
`define TMC_RST_NS     160
`define TMC_RST_CYC    ((`TMC_RST_NS + `TMC_CLK_NS - 1) / `TMC_CLK_NS)
`endif

//--- rtl/tmc_pkg.sv
package tmc_pkg;
  typedef logic [1:0] tmc_resp_t;
  typedef logic [7:0] tmc_pin_t;
  typedef enum logic [0:0] {
    TMC_WD_IDLE  = 1'b0,
    TMC_WD_ARMED = 1'b1
  } tmc_wd_t;
  typedef enum logic [1:0] {
    TMC_EDGE_OFF  = 2'b00,
    TMC_EDGE_RISE = 2'b01,
    TMC_EDGE_FALL = 2'b10,
    TMC_EDGE_ANY  = 2'b11
  } tmc_edge_t;
endpackage

//--- sim/tmc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_model (
  input  wire tmc_pkg::tmc_pin_t ext_lvl,
  input  wire tmc_pkg::tmc_pin_t port_out,
  input  wire tmc_pkg::tmc_pin_t port_oe,
  output tmc_pkg::tmc_pin_t      port_in
);
  import tmc_pkg::*;
  // Outside drivers stand back wherever the core drives, so a pin the
  // core owns reads back its own level and never an unknown
  always_comb port_in = (port_oe & port_out) | (~port_oe & ext_lvl);
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/100ps
`include "tmc_defs.svh"
`default_nettype none
module tb;
  import tmc_pkg::*;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [7:0]            s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]            s_axi_wstrb = 4'hf;
  logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic                  s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic                  s_axi_rready = 1'b0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                  s_axi_arready, s_axi_rvalid, rst_pin_out_n;
  tmc_resp_t             s_axi_bresp, s_axi_rresp, rsp;
  tmc_pin_t              port_in, port_out, port_oe;
  tmc_pin_t              ext_lvl = 8'h00;
  logic [`TMC_NFLAG-1:0] irq_vec;
  int                    errors = 0, check_count = 0, cyc = 0, tk = 0;

  // Two ticks so a service between ticks can never be overtaken
  tmc_core #(.WDOG_TICKS(2)) i_tmc_core (.ref_clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_in, .port_out,
    .port_oe, .irq_vec, .rst_pin_out_n);
  tmc_pin_model i_tmc_pin_model (.ext_lvl, .port_out, .port_oe, .port_in);

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100) begin
      errors++;
      test_done();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        tk = cyc;
      end
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) begin
      errors++;
      test_done();
    end
  endtask

  task automatic svc;
    wr(`TMC_WDOG_OFS, {24'h0, `TMC_WD_KEY1});
    wr(`TMC_WDOG_OFS, {24'h0, `TMC_WD_KEY2});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_start;
    logic [31:0] a, b;
    rd(`TMC_COUNT_OFS, a);
    chk(32'(a < 40), 32'h1);
    rd(`TMC_CTRL_OFS, b);
    chk(b, `TMC_CTRL_RST);
    rd(`TMC_EDGE_OFS, b);
    chk(b, 32'(`TMC_EDGE_RST));
    chk(32'(irq_vec), 32'h0);
    wr(`TMC_COUNT_OFS, 32'h0);
    rd(`TMC_COUNT_OFS, b);
    chk(32'(((b - a) & 32'hffff) < 60 && b != a), 32'h1);
    rd(8'h3c, b);
    chk({rsp, b}, {2'b10, 32'h0});
  endtask

  task automatic t_overflow;
    logic [31:0] f;
    logic        bad;
    int          n;
    bad = 1'b0;
    wr(`TMC_IEN_OFS, 32'h100);
    for (n = 0; n < 70000 && irq_vec[`TMC_FLG_TOV] !== 1'b1; n++) begin
      @(posedge ref_clk);
      if (rst_pin_out_n !== 1'b1) bad = 1'b1;
      if (n % 16000 == 0) svc();
    end
    chk(bad, 1'b0);
    chk(32'(n < 70000), 32'h1);
    rd(`TMC_COUNT_OFS, f);
    chk(32'(f < 60), 32'h1);
    rd(`TMC_FLAG_OFS, f);
    chk(f[`TMC_FLG_TOV], 1'b1);
    wr(`TMC_IEN_OFS, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk(irq_vec[`TMC_FLG_TOV], 1'b0);
    wr(`TMC_FLAG_OFS, 32'h100);
    rd(`TMC_FLAG_OFS, f);
    chk(f[`TMC_FLG_TOV], 1'b0);
  endtask

  task automatic t_capture;
    logic [31:0] a, v, f;
    wr(`TMC_CTRL_OFS, 32'h80);
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 4; c++) begin
        wr(`TMC_EDGE_OFS, 32'(c) << (2 * i));
        wr(`TMC_FLAG_OFS, 32'hff);
        rd(`TMC_COUNT_OFS, a);
        ext_lvl[i] <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rd(`TMC_FLAG_OFS, f);
        chk(f[i], c[0]);
        rd(`TMC_PORT_OFS, v);
        chk(v[i], 1'b1);
        if (c[0]) begin
          rd(8'h40 + 8'(4 * i), v);
          chk(32'(((v - a) & 32'hffff) < 40), 32'h1);
        end
        wr(`TMC_FLAG_OFS, 32'hff);
        ext_lvl[i] <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(`TMC_FLAG_OFS, f);
        chk(f[i], c[1]);
      end
    end
  endtask

  task automatic t_accum;
    logic [31:0] v, w;
    wr(`TMC_CTRL_OFS, 32'h50);
    wr(`TMC_PACNT_OFS, 32'h0);
    repeat (3) begin
      ext_lvl[7] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      ext_lvl[7] <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
    rd(`TMC_PACNT_OFS, v);
    chk(v, 32'h3);
    chk(32'(port_oe[7]), 32'h0);
    // Gated mode counts the E/64 clock while the pin stays high
    wr(`TMC_CTRL_OFS, 32'h70);
    wr(`TMC_PACNT_OFS, 32'h0);
    ext_lvl[7] <= 1'b1;
    repeat (640) @(posedge ref_clk);
    ext_lvl[7] <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(`TMC_PACNT_OFS, v);
    chk(32'(v >= 9 && v <= 11), 32'h1);
    repeat (640) @(posedge ref_clk);
    rd(`TMC_PACNT_OFS, w);
    chk(w, v);
  endtask

  task automatic t_prescale;
    logic [31:0] a, b, d;
    int          t, m;
    for (int p = 0; p < 4; p++) begin
      m = (p == 0) ? 1 : 2 << p;
      wr(`TMC_CTRL_OFS, 32'(p));
      rd(`TMC_COUNT_OFS, a);
      t = tk;
      repeat (64) @(posedge ref_clk);
      rd(`TMC_COUNT_OFS, b);
      t = tk - t;
      d = ((b - a) & 32'hffff) * m;
      chk(32'(d + m > t && d < t + m), 32'h1);
    end
  endtask

  task automatic t_compare;
    logic [31:0] a;
    rd(`TMC_COUNT_OFS, a);
    // Park every compare far ahead so no match toggles the pin meanwhile
    for (int i = 3; i < 8; i++) wr(8'h40 + 8'(4 * i), a + 32'h8000);
    wr(`TMC_PORT_OFS, 32'h4040);
    repeat (2) @(posedge ref_clk);
    chk({port_oe[6], port_out[6]}, 2'b11);
    wr(`TMC_CTRL_OFS, 32'h100);
    wr(`TMC_PORT_OFS, 32'h4040);
    repeat (2) @(posedge ref_clk);
    chk({port_oe[6], port_out[6]}, 2'b10);
  endtask

  task automatic t_watchdog;
    int n;
    svc();
    for (n = 0; n < 70000 && rst_pin_out_n !== 1'b0; n++) @(posedge ref_clk);
    chk(32'(n >= 32000 && n < 70000), 32'h1);
    for (n = 0; n < 20 && rst_pin_out_n === 1'b0; n++) @(posedge ref_clk);
    chk(32'(n), 32'h4);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_start();
    t_overflow();
    svc();
    t_capture();
    svc();
    t_accum();
    t_prescale();
    t_compare();
    t_watchdog();
    test_done();
  end
endmodule
`default_nettype wire
